// >>> core/dual_event_counter_unit.sv
// Two 40-bit event and duration counters with control register and monitor pins
//
// Function
// R1 - Two independent 40-bit event or duration counters
// R2 - Register access only by kernel-level model instructions
// R3 - Event code fields at bits 0-5, 16-21
// R4 - Count mode fields at bits 6-8, 22-24
// R5 - Modes 000 and 100 hold counter still
// R6 - Mode bits: duration, user level, kernel levels
// R7 - Pin flag picks overflow or increment indication
// R8 - Pin follows internal condition a few clocks late
// R9 - Software stops and clears before changing event
// R10 - Software rewrites whole control register each time
// R11 - Reset clears control, counters disabled
// R12 - One pin pulse per incrementing clock
// R13 - Duration adds one per true clock
// R14 - Occurrence counter adds one or two
// R15 - Overflow is carry out of bit 39
// R16 - Overflow pin asserts five clocks later
// R17 - Debugger may take pins for breakpoints
// R18 - Software avoids reserved event codes
// R19 - Counter wraps to zero and keeps counting
`timescale 1ns/1ps
`default_nettype none
module dual_event_counter_unit
	import evc_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic arst_n,

	// Model register access
	input wire logic model_register_read,
	input wire logic model_register_write,
	input wire logic [1:0] reg_sel,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic [1:0] current_privilege_level,
	output logic [DATA_W-1:0] reg_rdata,
	output logic reg_done,
	output logic reg_fault,

	// Event sources
	input wire logic [NUM_CODES-1:0][1:0] event_count,
	input wire logic [NUM_CODES-1:0] event_active,

	// Debugger control of the pins
	input wire logic [1:0] debug_takeover,
	input wire logic [1:0] debug_bp_match,

	// Monitor pins
	output logic monitor_pin_zero,
	output logic monitor_pin_one
);

	typedef struct packed {
		logic [CTRL_W-1:0] ctrl;
		logic [NUM_CTR-1:0][CTR_W-1:0] cnt;
		logic [DATA_W-1:0] rdata;
		logic done;
		logic fault;
	} core_state_type;

	core_state_type st_r;
	core_state_type st_nxt;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);

	logic access_req;
	logic access_ok;
	logic sel_valid;
	wire [CTR_W:0] inc_sum [NUM_CTR];
	wire [NUM_CTR-1:0] wr_ctr;
	wire [NUM_CTR-1:0] ind_w;
	logic [1:0] pins;

	pin_link_if lnk();

	// Write wins when both instructions arrive together
	assign access_req = model_register_read || model_register_write;
	assign sel_valid = (reg_sel == SEL_CONTROL) || (reg_sel == SEL_COUNT0) || (reg_sel == SEL_COUNT1);
	assign access_ok = access_req && (current_privilege_level == CPL_KERNEL) && sel_valid; // [R2]

	for (genvar i = 0; i < NUM_CTR; i++) begin : g_ctr
		localparam logic [1:0] MY_SEL = (i == 0) ? SEL_COUNT0 : SEL_COUNT1;
		logic [CODE_W-1:0] code;
		logic [MODE_W-1:0] mode;
		logic pinf;
		logic allowed;
		logic [1:0] occ;
		logic [1:0] amt;
		logic [CTR_W:0] sum;

		assign code = st_r.ctrl[i*CTR_STRIDE+CODE_LSB +: CODE_W]; // [R3]
		assign mode = st_r.ctrl[i*CTR_STRIDE+MODE_LSB +: MODE_W]; // [R4]
		assign pinf = st_r.ctrl[i*CTR_STRIDE+PINF_LSB];

		// Both level bits clear means disabled whatever the top bit says
		assign allowed = (mode[MODE_USER_BIT] && (current_privilege_level == CPL_USER))
			|| (mode[MODE_SUPV_BIT] && (current_privilege_level != CPL_USER)); // [R5] [R6]

		// More than two events a clock cannot happen; clamp just in case
		assign occ = (event_count[code] == 2'h3) ? 2'h2 : event_count[code]; // [R14]

		assign wr_ctr[i] = access_ok && model_register_write && (reg_sel == MY_SEL);

		// A software write replaces the count, so no increment that clock
		assign amt = (!allowed || wr_ctr[i]) ? 2'h0
			: (mode[MODE_DUR_BIT] ? {1'b0, event_active[code]} : occ); // [R13] [R14]

		assign sum = {1'b0, st_r.cnt[i]} + {{(CTR_W-1){1'b0}}, amt}; // [R1] [R19]
		assign inc_sum[i] = sum;

		// Carry out of the top bit is the overflow
		assign ind_w[i] = pinf ? sum[CTR_W] : (amt != 2'h0); // [R7] [R12] [R15]

		AST_DISABLED_HOLD: assert property (@(posedge core_clk) disable iff (!arst_n) // [R5]
			(mode[1:0] == 2'b00) && !wr_ctr[i] |=> $stable(st_r.cnt[i]))
			else $error("disabled counter changed");

		AST_PRIV_FILTER: assert property (@(posedge core_clk) disable iff (!arst_n) // [R6]
			(current_privilege_level == CPL_USER) && !mode[MODE_USER_BIT] && !wr_ctr[i]
			|=> $stable(st_r.cnt[i]))
			else $error("counter advanced at filtered privilege level");

		AST_DUR_ADD: assert property (@(posedge core_clk) disable iff (!arst_n) // [R13]
			mode[MODE_DUR_BIT] && allowed && event_active[code] && !wr_ctr[i] && (st_r.cnt[i] != CNT_MAX)
			|-> (pinf || ind_w[i]) ##1 st_r.cnt[i] == $past(st_r.cnt[i]) + 40'h1)
			else $error("duration counter did not add one");

		AST_OCC_TWO: assert property (@(posedge core_clk) disable iff (!arst_n) // [R14] [R12]
			!mode[MODE_DUR_BIT] && allowed && (event_count[code] == 2'h2) && !wr_ctr[i] && !pinf
			&& (st_r.cnt[i] < CNT_MAX - 40'h1)
			|-> ind_w[i] ##1 st_r.cnt[i] == $past(st_r.cnt[i]) + 40'h2)
			else $error("double event did not add two with one indication");

		AST_WRAP: assert property (@(posedge core_clk) disable iff (!arst_n) // [R19] [R15]
			(st_r.cnt[i] == CNT_MAX) && (amt != 2'h0)
			|-> (ind_w[i] || !pinf) ##1 (st_r.cnt[i] < 40'h2))
			else $error("counter did not wrap with overflow");

		AST_CNT_WRITE: assert property (@(posedge core_clk) disable iff (!arst_n) // [R1]
			wr_ctr[i] |=> st_r.done && (st_r.cnt[i] == $past(reg_wdata[CTR_W-1:0])))
			else $error("counter write not taken");

		sequence s_occ_counting;
			!mode[MODE_DUR_BIT] && allowed && !wr_ctr[i];
		endsequence

		AST_OCC_ONE: assert property (@(posedge core_clk) disable iff (!arst_n) // [R14]
			s_occ_counting ##0 ((event_count[code] == 2'h1) && (st_r.cnt[i] != CNT_MAX))
			|=> st_r.cnt[i] == $past(st_r.cnt[i]) + 40'h1)
			else $error("single event did not add one");

		AST_OCC_CLAMP: assert property (@(posedge core_clk) disable iff (!arst_n) // [R14]
			s_occ_counting ##0 ((event_count[code] == 2'h3) && (st_r.cnt[i] < CNT_MAX - 40'h1))
			|=> st_r.cnt[i] == $past(st_r.cnt[i]) + 40'h2)
			else $error("triple event report not clamped to two");

		AST_OCC_IDLE: assert property (@(posedge core_clk) disable iff (!arst_n) // [R14]
			s_occ_counting ##0 (event_count[code] == 2'h0) |=> $stable(st_r.cnt[i]))
			else $error("counter moved without an event");

		AST_DUR_IDLE: assert property (@(posedge core_clk) disable iff (!arst_n) // [R13]
			mode[MODE_DUR_BIT] && !event_active[code] && !wr_ctr[i] |=> $stable(st_r.cnt[i]))
			else $error("duration counter moved while condition false");

		AST_SUPV_FILTER: assert property (@(posedge core_clk) disable iff (!arst_n) // [R6]
			(current_privilege_level != CPL_USER) && !mode[MODE_SUPV_BIT] && !wr_ctr[i]
			|=> $stable(st_r.cnt[i]))
			else $error("counter advanced at filtered kernel level");

		AST_INC_PIN: assert property (@(posedge core_clk) disable iff (!arst_n) // [R12]
			s_occ_counting ##0 (!pinf && (event_count[code] != 2'h0)) |-> ind_w[i])
			else $error("increment not indicated");

		AST_DUR_PIN: assert property (@(posedge core_clk) disable iff (!arst_n) // [R13]
			mode[MODE_DUR_BIT] && allowed && !wr_ctr[i] && !pinf && event_active[code] |-> ind_w[i])
			else $error("duration condition not indicated");

		AST_NO_COUNT_QUIET: assert property (@(posedge core_clk) disable iff (!arst_n) // [R5] [R7]
			!allowed || wr_ctr[i] |-> !ind_w[i])
			else $error("indication from a counter that did not move");

		AST_OVF_QUIET: assert property (@(posedge core_clk) disable iff (!arst_n) // [R7] [R15]
			pinf && (st_r.cnt[i] < CNT_MAX - 40'h1) |-> !ind_w[i])
			else $error("overflow indicated without a carry");

		AST_OVF_SHOW: assert property (@(posedge core_clk) disable iff (!arst_n) // [R15]
			pinf && (st_r.cnt[i] == CNT_MAX) && allowed && !wr_ctr[i]
			&& (mode[MODE_DUR_BIT] ? event_active[code] : (event_count[code] != 2'h0)) |-> ind_w[i])
			else $error("carry out of the top bit not indicated");
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		st_nxt.fault = 1'b0;
		for (int k = 0; k < NUM_CTR; k++) begin
			st_nxt.cnt[k] = inc_sum[k][CTR_W-1:0]; // [R19]
		end
		if (access_req && !access_ok) begin
			st_nxt.fault = 1'b1; // [R2]
		end else if (access_ok) begin
			st_nxt.done = 1'b1;
			if (model_register_write) begin
				case (reg_sel)
					SEL_CONTROL: begin
						st_nxt.ctrl = reg_wdata[CTRL_W-1:0] & CTRL_MASK; // [R3] [R4] [R7]
					end
					SEL_COUNT0: begin
						st_nxt.cnt[0] = reg_wdata[CTR_W-1:0];
					end
					SEL_COUNT1: begin
						st_nxt.cnt[1] = reg_wdata[CTR_W-1:0];
					end
					default: begin
						st_nxt.fault = 1'b1;
					end
				endcase
			end else begin
				// A read sees the count before this clock's increment
				case (reg_sel)
					SEL_CONTROL: begin
						st_nxt.rdata = {{(DATA_W-CTRL_W){1'b0}}, st_r.ctrl};
					end
					SEL_COUNT0: begin
						st_nxt.rdata = {{(DATA_W-CTR_W){1'b0}}, st_r.cnt[0]};
					end
					SEL_COUNT1: begin
						st_nxt.rdata = {{(DATA_W-CTR_W){1'b0}}, st_r.cnt[1]};
					end
					default: begin
						st_nxt.fault = 1'b1;
					end
				endcase
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r.ctrl <= CTRL_RESET; // [R11]
			st_r.cnt <= {NUM_CTR{CNT_RESET}};
			st_r.rdata <= '0;
			st_r.done <= 1'b0;
			st_r.fault <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Pin indication travels to the lag pipeline
	assign lnk.ind = ind_w;
	assign lnk.takeover = debug_takeover; // [R17]
	assign lnk.bp_match = debug_bp_match;

	monitor_pin_driver u_pins (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.lnk(lnk.sink),
		.pins(pins)
	);

	assign monitor_pin_zero = pins[0];
	assign monitor_pin_one = pins[1];
	assign reg_rdata = st_r.rdata;
	assign reg_done = st_r.done;
	assign reg_fault = st_r.fault;

	sequence s_kernel_write(logic [1:0] s);
		model_register_write && (current_privilege_level == CPL_KERNEL) && (reg_sel == s);
	endsequence

	sequence s_kernel_read(logic [1:0] s);
		model_register_read && !model_register_write && (current_privilege_level == CPL_KERNEL) && (reg_sel == s);
	endsequence

	AST_CTRL_RESERVED: assert property ( // [R3]
		(st_r.ctrl & ~CTRL_MASK) == 32'h0000_0000)
		else $error("reserved control bits not zero");

	AST_CTRL_WRITE: assert property ( // [R4]
		s_kernel_write(SEL_CONTROL) |=> st_r.done && (st_r.ctrl == ($past(reg_wdata[CTRL_W-1:0]) & CTRL_MASK)))
		else $error("control write not stored");

	AST_PRIV_REFUSE: assert property ( // [R2]
		access_req && (current_privilege_level != CPL_KERNEL)
		|=> st_r.fault && !st_r.done && $stable(st_r.ctrl))
		else $error("non-kernel access not refused");

	AST_READ_COUNT: assert property ( // [R2]
		s_kernel_read(SEL_COUNT0) |=> st_r.done && (reg_rdata == {24'h00_0000, $past(st_r.cnt[0])}))
		else $error("counter zero read wrong");

	AST_READ_CTRL: assert property ( // [R11]
		s_kernel_read(SEL_CONTROL) |=> st_r.done && (reg_rdata == {32'h0000_0000, $past(st_r.ctrl)}))
		else $error("control read wrong");

	sequence s_refused;
		access_req && ((current_privilege_level != CPL_KERNEL) || (reg_sel == 2'h3));
	endsequence

	AST_SEL_REFUSE: assert property ( // [R2]
		access_req && (reg_sel == 2'h3) |=> st_r.fault && !st_r.done)
		else $error("invalid register select not refused");

	AST_REFUSE_KEEP: assert property ( // [R2]
		s_refused |=> $stable(st_r.ctrl) && $stable(reg_rdata))
		else $error("refused access changed state");

	AST_ACCEPT: assert property ( // [R2]
		access_ok |=> st_r.done && !st_r.fault)
		else $error("kernel access not answered");

	AST_IDLE_QUIET: assert property ( // [R2]
		!access_req |=> !st_r.done && !st_r.fault)
		else $error("answer without a request");

	AST_FAULT_EXCL: assert property ( // [R2]
		!(st_r.done && st_r.fault))
		else $error("done and fault together");

	AST_RDATA_HOLD: assert property ( // [R2]
		(!model_register_read || model_register_write) |=> $stable(reg_rdata))
		else $error("read data changed without a read");

	AST_RDATA_TOP: assert property ( // [R1]
		reg_rdata[DATA_W-1:CTR_W] == 24'h00_0000)
		else $error("read data above the counter width not zero");

	AST_CTRL_HOLD: assert property ( // [R4]
		!model_register_write || (current_privilege_level != CPL_KERNEL) || (reg_sel != SEL_CONTROL)
		|=> $stable(st_r.ctrl))
		else $error("control changed without a kernel write");

	AST_WRITE_WINS: assert property ( // [R2]
		s_kernel_write(SEL_COUNT0) ##0 model_register_read
		|=> (st_r.cnt[0] == $past(reg_wdata[CTR_W-1:0])) && $stable(reg_rdata))
		else $error("write did not win over read");

	AST_READ_COUNT_ONE: assert property ( // [R1]
		s_kernel_read(SEL_COUNT1) |=> st_r.done && (reg_rdata == {24'h00_0000, $past(st_r.cnt[1])}))
		else $error("counter one read wrong");
endmodule // dual_event_counter_unit
`default_nettype wire

// >>> core/evc_pkg.sv
// Constants and types shared by the dual event counter unit
package evc_pkg;
	// Widths
	localparam int unsigned CTR_W = 40;
	localparam int unsigned CTRL_W = 32;
	localparam int unsigned DATA_W = 64;
	localparam int unsigned NUM_CTR = 2;
	localparam int unsigned CODE_W = 6;
	localparam int unsigned NUM_CODES = 64;
	localparam int unsigned MODE_W = 3;

	// Control field positions; counter one sits one stride above counter zero
	localparam int unsigned CODE_LSB = 0;
	localparam int unsigned MODE_LSB = 6;
	localparam int unsigned PINF_LSB = 9;
	localparam int unsigned CTR_STRIDE = 16;
	localparam int unsigned MODE_DUR_BIT = 2;
	localparam int unsigned MODE_USER_BIT = 1;
	localparam int unsigned MODE_SUPV_BIT = 0;

	// Values after reset and implemented control bits
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] CTRL_MASK = 32'h03ff_03ff;
	localparam logic [39:0] CNT_RESET = 40'h00_0000_0000;
	localparam logic [39:0] CNT_MAX = 40'hff_ffff_ffff;

	// Privilege levels
	localparam logic [1:0] CPL_KERNEL = 2'h0;
	localparam logic [1:0] CPL_USER = 2'h3;

	// Internal event to external pin lag, in core clocks
	localparam int unsigned PIN_LAG_CYCLES = 5;

	// Register select codes
	typedef enum logic [1:0] {
		SEL_CONTROL = 2'b00,
		SEL_COUNT0 = 2'b01,
		SEL_COUNT1 = 2'b10
	} reg_sel_type;
endpackage

// >>> core/monitor_pin_driver.sv
// Lag pipeline and debugger takeover for the monitor pins
`timescale 1ns/1ps
`default_nettype none
module monitor_pin_driver
	import evc_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// Indication from counter core
	pin_link_if.sink lnk,
	// Pins
	output logic [1:0] pins
);
	localparam int LAG_M1 = PIN_LAG_CYCLES - 1;
	localparam int unsigned DEPTH = PIN_LAG_CYCLES - 1;

	typedef struct packed {
		logic [1:0] tk_s1;
		logic [1:0] tk_s2;
		logic [1:0] bp_s1;
		logic [1:0] bp_s2;
		logic [1:0][DEPTH-1:0] pipe;
		logic [1:0] pin;
	} pin_state_type;

	pin_state_type st_r;
	pin_state_type st_nxt;

	always_comb begin
		st_nxt = st_r;
		// Debugger lines are asynchronous, so two flops first
		st_nxt.tk_s1 = lnk.takeover;
		st_nxt.tk_s2 = st_r.tk_s1;
		st_nxt.bp_s1 = lnk.bp_match;
		st_nxt.bp_s2 = st_r.bp_s1;
		for (int k = 0; k < NUM_CTR; k++) begin
			st_nxt.pipe[k] = {st_r.pipe[k][DEPTH-2:0], lnk.ind[k]}; // [R8] [R16]
			st_nxt.pin[k] = st_r.tk_s2[k] ? st_r.bp_s2[k] : st_r.pipe[k][DEPTH-1]; // [R17]
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pins = st_r.pin;

	for (genvar i = 0; i < NUM_CTR; i++) begin : g_chk
		sequence s_ind_then_free;
			lnk.ind[i] ##LAG_M1 !st_r.tk_s2[i];
		endsequence
		AST_PIN_LAG: assert property (@(posedge core_clk) disable iff (!arst_n) // [R16]
			s_ind_then_free |=> st_r.pin[i])
			else $error("monitor pin missed lagged indication");
		AST_PIN_QUIET: assert property (@(posedge core_clk) disable iff (!arst_n) // [R8]
			!lnk.ind[i] ##LAG_M1 !st_r.tk_s2[i] |=> !st_r.pin[i])
			else $error("monitor pin asserted without cause");
		AST_BP_TAKE: assert property (@(posedge core_clk) disable iff (!arst_n) // [R17]
			st_r.tk_s2[i] |=> st_r.pin[i] == $past(st_r.bp_s2[i]))
			else $error("breakpoint match not shown on taken pin");
	end
endmodule // monitor_pin_driver
`default_nettype wire

// >>> core/pin_link_if.sv
// Link between counter core and monitor pin driver
`timescale 1ns/1ps
`default_nettype none
interface pin_link_if;
	logic [1:0] ind;
	logic [1:0] takeover;
	logic [1:0] bp_match;
	modport source(output ind, output takeover, output bp_match);
	modport sink(input ind, input takeover, input bp_match);
endinterface
`default_nettype wire

// >>> verification/dual_event_counter_unit_bench.sv
// Self-checking bench for the dual event counter unit
`timescale 1ns/1ps
`default_nettype none
module dual_event_counter_unit_bench
	import evc_pkg::*;
;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic model_register_read = 1'b0;
	logic model_register_write = 1'b0;
	logic [1:0] reg_sel = 2'h0;
	logic [DATA_W-1:0] reg_wdata = 64'h0;
	logic [1:0] current_privilege_level = 2'h0;
	logic [NUM_CODES-1:0][1:0] event_count = '0;
	logic [NUM_CODES-1:0] event_active = '0;
	logic [1:0] debug_takeover = 2'h0;
	logic [1:0] debug_bp_match = 2'h0;
	logic [DATA_W-1:0] reg_rdata;
	logic reg_done, reg_fault, monitor_pin_zero, monitor_pin_one;
	logic [31:0] seen_zero, seen_one;
	int err_total = 0;
	int samples_checked = 0;
	// Note: fault, data valid, data
	logic [65:0] notes[$];

	initial begin
		forever #10 core_clk = ~core_clk;
	end

	dual_event_counter_unit dut (.core_clk, .arst_n, .model_register_read, .model_register_write, .reg_sel,
		.reg_wdata, .current_privilege_level, .reg_rdata, .reg_done, .reg_fault, .event_count, .event_active,
		.debug_takeover, .debug_bp_match, .monitor_pin_zero, .monitor_pin_one);
	pin_watcher watch (.core_clk, .arst_n, .monitor_pin_zero, .monitor_pin_one, .seen_zero, .seen_one);

	task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic print_verdict();
		if (err_total == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// One access per clock, so calls run back to back
	task automatic acc(input logic w, input logic [1:0] s, input logic [63:0] d, input logic [1:0] p,
		input logic chk, input logic [63:0] exp);
		@(posedge core_clk);
		model_register_write <= w;
		model_register_read <= ~w;
		reg_sel <= s;
		reg_wdata <= d;
		current_privilege_level <= p;
		notes.push_back({p != 2'h0 || s == 2'h3, chk, exp});
	endtask

	task automatic idle();
		@(posedge core_clk);
		model_register_read <= 1'b0;
		model_register_write <= 1'b0;
		current_privilege_level <= 2'h0;
		for (int i = 0; i < 20 && notes.size() > 0; i++) @(posedge core_clk);
		if (notes.size() > 0) begin
			cmp("answer wait", 64'h0, 64'h1);
			print_verdict();
		end
	endtask

	function automatic logic [1:0] inc(input logic [2:0] md, input logic [1:0] pl, input logic [1:0] n,
		input logic a);
		if (!((pl == 2'h3) ? md[1] : md[0])) return 2'h0;
		if (md[2]) return {1'b0, a};
		return (n == 2'h3) ? 2'h2 : n;
	endfunction

	always @(posedge core_clk) begin : answers
		logic [65:0] n;
		if (reg_done === 1'b1 || reg_fault === 1'b1) begin
			if (notes.size() == 0) begin
				cmp("unexpected answer", 64'h0, 64'h1);
			end else begin
				n = notes.pop_front();
				cmp("answer", {62'h0, n[65], ~n[65]}, {62'h0, reg_fault, reg_done});
				if (n[64]) cmp("read data", n[63:0], reg_rdata);
			end
		end
	end

	initial begin
		logic [NUM_CODES-1:0][1:0] ev;
		logic [NUM_CODES-1:0] ea;
		logic [63:0] e0, e1;
		logic [31:0] p0, p1, ctl;
		logic [5:0] c0, c1;
		logic [1:0] pl, k0, k1;
		int q0, q1;
		void'($urandom(50));
		repeat (10) @(posedge core_clk);
		arst_n <= 1'b1;
		acc(1'b0, SEL_CONTROL, 64'h0, 2'h0, 1'b1, 64'h0);
		acc(1'b0, SEL_COUNT0, 64'h0, 2'h0, 1'b1, 64'h0);
		acc(1'b1, SEL_CONTROL, '1, 2'h0, 1'b0, 64'h0);
		acc(1'b0, SEL_CONTROL, 64'h0, 2'h0, 1'b1, 64'h0000_0000_03ff_03ff);
		acc(1'b1, SEL_CONTROL, 64'h0, 2'h1, 1'b0, 64'h0);
		acc(1'b0, SEL_CONTROL, 64'h0, 2'h3, 1'b0, 64'h0);
		acc(1'b0, 2'h3, 64'h0, 2'h0, 1'b0, 64'h0);
		acc(1'b0, SEL_CONTROL, 64'h0, 2'h0, 1'b1, 64'h0000_0000_03ff_03ff);
		acc(1'b1, SEL_CONTROL, 64'h0, 2'h0, 1'b0, 64'h0);
		acc(1'b1, SEL_COUNT1, '1, 2'h0, 1'b0, 64'h0);
		acc(1'b0, SEL_COUNT1, 64'h0, 2'h0, 1'b1, 64'h0000_00ff_ffff_ffff);
		idle();
		// Every mode on counter zero, the mirror mode on counter one
		for (int m = 0; m < 8; m++) begin
			c0 = 6'($urandom);
			c1 = 6'($urandom);
			ctl = {6'h0, 1'b0, 3'(7 - m), c1, 6'h0, 1'b0, 3'(m), c0};
			acc(1'b1, SEL_CONTROL, 64'h0, 2'h0, 1'b0, 64'h0);
			acc(1'b1, SEL_COUNT0, 64'h0, 2'h0, 1'b0, 64'h0);
			acc(1'b1, SEL_COUNT1, 64'h0, 2'h0, 1'b0, 64'h0);
			acc(1'b1, SEL_CONTROL, {32'h0, ctl}, 2'h0, 1'b0, 64'h0);
			idle();
			e0 = 64'h0;
			e1 = 64'h0;
			q0 = 0;
			q1 = 0;
			p0 = seen_zero;
			p1 = seen_one;
			repeat (12) begin
				ev = {$urandom, $urandom, $urandom, $urandom};
				ea = {$urandom, $urandom};
				pl = 2'($urandom);
				k0 = inc(3'(m), pl, ev[c0], ea[c0]);
				k1 = inc(3'(7 - m), pl, ev[c1], ea[c1]);
				e0 += 64'(k0);
				e1 += 64'(k1);
				q0 += int'(k0 != 2'h0);
				q1 += int'(k1 != 2'h0);
				@(posedge core_clk);
				event_count <= ev;
				event_active <= ea;
				current_privilege_level <= pl;
			end
			@(posedge core_clk);
			event_count <= '0;
			event_active <= '0;
			current_privilege_level <= 2'h0;
			repeat (8) @(posedge core_clk);
			acc(1'b0, SEL_COUNT0, 64'h0, 2'h0, 1'b1, e0);
			acc(1'b0, SEL_COUNT1, 64'h0, 2'h0, 1'b1, e1);
			idle();
			cmp("pin zero pulses", 64'(q0), 64'(seen_zero - p0));
			cmp("pin one pulses", 64'(q1), 64'(seen_one - p1));
		end
		// Reset in mid-run must clear what the loop left enabled
		arst_n <= 1'b0;
		@(posedge core_clk);
		arst_n <= 1'b1;
		acc(1'b0, SEL_CONTROL, 64'h0, 2'h0, 1'b1, 64'h0);
		// Preset to the top, then a double event carries out of bit 39
		acc(1'b1, SEL_COUNT0, {24'h0, CNT_MAX}, 2'h0, 1'b0, 64'h0);
		acc(1'b1, SEL_CONTROL, 64'h0000_0000_0000_02c0, 2'h0, 1'b0, 64'h0);
		idle();
		@(posedge core_clk);
		event_count <= 128'h2;
		@(posedge core_clk);
		event_count <= '0;
		repeat (3) @(posedge core_clk);
		#1 cmp("overflow pin early", 64'h0, {63'h0, monitor_pin_zero});
		@(posedge core_clk);
		#1 cmp("overflow pin", 64'h1, {63'h0, monitor_pin_zero});
		@(posedge core_clk);
		#1 cmp("overflow pin late", 64'h0, {63'h0, monitor_pin_zero});
		acc(1'b0, SEL_COUNT0, 64'h0, 2'h0, 1'b1, 64'h1);
		// Read and write together: the write must win
		@(posedge core_clk);
		model_register_read <= 1'b1;
		model_register_write <= 1'b1;
		reg_sel <= SEL_COUNT0;
		reg_wdata <= 64'h5;
		notes.push_back(66'h0);
		acc(1'b0, SEL_COUNT0, 64'h0, 2'h0, 1'b1, 64'h5);
		idle();
		// Debugger owns both pins
		debug_takeover <= 2'h3;
		debug_bp_match <= 2'h2;
		repeat (6) @(posedge core_clk);
		#1 cmp("takeover pins", 64'h2, {62'h0, monitor_pin_one, monitor_pin_zero});
		@(posedge core_clk);
		debug_takeover <= 2'h0;
		debug_bp_match <= 2'h0;
		repeat (6) @(posedge core_clk);
		print_verdict();
	end
endmodule // dual_event_counter_unit_bench
`default_nettype wire

// >>> verification/pin_watcher.sv
// Monitor pin high-cycle counter standing outside the chip
`timescale 1ns/1ps
`default_nettype none
module pin_watcher (
	// Clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// Pins under watch
	input wire logic monitor_pin_zero,
	input wire logic monitor_pin_one,
	// High-cycle totals
	output logic [31:0] seen_zero,
	output logic [31:0] seen_one
);
	// Pins lag the counters, so totals settle a few clocks late
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			seen_zero <= 32'h0;
			seen_one <= 32'h0;
		end else begin
			seen_zero <= seen_zero + {31'h0, monitor_pin_zero};
			seen_one <= seen_one + {31'h0, monitor_pin_one};
		end
	end
endmodule // pin_watcher
`default_nettype wire
